// >>> core/rta_byte_reg.sv
// One byte of host-writable storage with a hardware load port
`timescale 1ns/10ps
module rta_byte_reg
  import rta_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       hw_load,
  input  wire logic [7:0] hw_data,
  output logic      [7:0] q
);
  typedef struct packed {
    logic [7:0] val;
  } rta_byte_s;

  rta_byte_s st_reg;
  rta_byte_s st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.val = wr_data;
    end
    // Hardware copy wins over a host write
    if (hw_load) begin
      st_next.val = hw_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_reg <= '{val: BYTE_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.val;
endmodule : rta_byte_reg

// >>> core/rta_osc_monitor.sv
// Oscillator edge tick and missing-clock timeout detector
`timescale 1ns/10ps
module rta_osc_monitor
  import rta_pkg::*;
#(
  parameter logic [MISS_CNT_W-1:0] MISS_LIMIT = MISS_CNT_W'(MISS_CYCLES)
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic osc_in,
  input  wire logic osc_on,
  input  wire logic detect_en,
  output logic      tick,
  output logic      timeout
);
  typedef struct packed {
    logic                  osc_d;
    logic [MISS_CNT_W-1:0] idle_cnt;
    logic                  fired;
  } rta_mon_s;

  rta_mon_s st_reg;
  rta_mon_s st_next;
  logic     edge_seen;

  assign edge_seen = osc_in ^ st_reg.osc_d;

  always_comb begin
    st_next       = st_reg;
    st_next.osc_d = osc_in;
    timeout       = 1'b0;
    if (!detect_en || edge_seen) begin
      st_next.idle_cnt = '0;
      st_next.fired    = 1'b0;
    end else if (st_reg.idle_cnt < MISS_LIMIT) begin
      st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
    end else if (!st_reg.fired) begin
      // One-shot: level stuck beyond the limit
      timeout       = 1'b1;
      st_next.fired = 1'b1;
    end
  end

  // Rising edge of the oscillator is one oscillator cycle
  assign tick = osc_on & osc_in & ~st_reg.osc_d;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_reg <= '{osc_d: 1'b0, idle_cnt: '0, fired: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : rta_osc_monitor

// >>> core/rta_pkg.sv
// Package with register map, field positions and timing counts for the timer and alarm block
// Function
// - A 32-bit counter advances once per oscillator cycle while running.
// - Run bit 0 holds the counter; run bit 1 lets it count.
// - With auto-reset on, counter clears one oscillator cycle after an alarm.
// - Writing bit 2 sets or clears auto-reset; reading it returns the alarm flag.
// - Load and snapshot work while the counter keeps running.
// - Load request copies the capture bytes into the counter, then self-clears.
// - Snapshot request copies the counter into the capture bytes, then self-clears.
// - Alarm fires when the whole 32-bit counter equals the match value.
// - Writing alarm enable 0 stops detection and clears the alarm flag.
// - Without auto-reset, re-enabling with the same match gives the next alarm 2^32 cycles later.
// - Alarm flag lasts at most one oscillator cycle; a latched request persists.
// - Alarm event can be routed to an interrupt or to a wake-up.
// - Without auto-reset the counter wraps through zero undisturbed.
// - Bit 7 switches the oscillator and its bias on or off.
// - Bit 6 enables the missing-clock detector; bit 5 flags its timeout.
// - Control bits: 7 osc, 6 detect, 5 fail, 4 run, 3 alarm, 2 flag, 1 load, 0 snap.
// - Oscillator stuck high or low beyond 100 us raises the fail flag.
// - Capture bytes hold the 32-bit value, bit 0 in the lowest-addressed byte.
package rta_pkg;
  localparam logic [3:0]  ADDR_CAPTURE0      = 4'h0;
  localparam logic [3:0]  ADDR_CONTROL       = 4'h4;
  localparam logic [3:0]  ADDR_MATCH0        = 4'h8;
  localparam int          CTRL_OSC_EN_BIT    = 7;
  localparam int          CTRL_MCD_EN_BIT    = 6;
  localparam int          CTRL_FAIL_BIT      = 5;
  localparam int          CTRL_RUN_BIT       = 4;
  localparam int          CTRL_AEN_BIT       = 3;
  localparam int          CTRL_ALARM_BIT     = 2;
  localparam int          CTRL_LOAD_BIT      = 1;
  localparam int          CTRL_SNAP_BIT      = 0;
  localparam logic [7:0]  CTRL_RESET         = 8'h00;
  localparam logic [7:0]  BYTE_RESET         = 8'h00;
  localparam logic [31:0] COUNT_RESET        = 32'h0000_0000;
  localparam int          CLK_MHZ            = 100;
  localparam int          MISS_TIME_US       = 100;
  localparam int          MISS_CYCLES        = MISS_TIME_US * CLK_MHZ;
  localparam int          MISS_CNT_W         = 16;
endpackage : rta_pkg

// >>> core/rta_timer_alarm.sv
// Real-time counter with equality alarm, auto-reset and capture transfers
`timescale 1ns/10ps
module rta_timer_alarm
  import rta_pkg::*;
#(
  parameter logic [MISS_CNT_W-1:0] MISS_LIMIT = MISS_CNT_W'(MISS_CYCLES)
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       osc_in,
  output logic            osc_enable,
  input  wire logic       alarm_wake_select,
  input  wire logic       irq_clear,
  output logic            alarm_irq,
  output logic            wake_req,
  output logic            alarm_event
);
  typedef struct packed {
    logic        osc_en;
    logic        mcd_en;
    logic        fail;
    logic        run;
    logic        aen;
    logic        autoreset;
    logic        load_req;
    logic        snap_req;
    logic        alarm_flag;
    logic        reset_pend;
    logic [31:0] count;
    logic [7:0]  rdata;
    logic        irq;
    logic        wake;
  } rta_state_s;

  rta_state_s  st_reg;
  rta_state_s  st_next;
  logic        tick;
  logic        timeout;
  logic [31:0] capture;
  logic [31:0] match;
  logic [3:0]  cap_wr;
  logic [3:0]  match_wr;
  logic        cap_load;
  logic        ctrl_wr;
  logic        fire;
  logic [7:0]  ctrl_view;

  rta_osc_monitor #(
    .MISS_LIMIT (MISS_LIMIT)
  ) u_mon (
    .mclk      (mclk),
    .rstn      (rstn),
    .osc_in    (osc_in),
    .osc_on    (st_reg.osc_en),
    .detect_en (st_reg.mcd_en),
    .tick      (tick),
    .timeout   (timeout)
  );

  // Snapshot lands in the capture bytes on an oscillator tick
  assign cap_load = tick & st_reg.snap_req;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bytes
      assign cap_wr[gi]   = reg_wr && (reg_addr == ADDR_CAPTURE0 + 4'(gi));
      assign match_wr[gi] = reg_wr && (reg_addr == ADDR_MATCH0 + 4'(gi));

      // Byte 0 at the lowest address holds bit 0
      rta_byte_reg u_cap (
        .mclk    (mclk),
        .rstn    (rstn),
        .wr_en   (cap_wr[gi]),
        .wr_data (reg_wdata),
        .hw_load (cap_load),
        .hw_data (st_reg.count[gi*8 +: 8]),
        .q       (capture[gi*8 +: 8])
      );

      rta_byte_reg u_match (
        .mclk    (mclk),
        .rstn    (rstn),
        .wr_en   (match_wr[gi]),
        .wr_data (reg_wdata),
        .hw_load (1'b0),
        .hw_data (BYTE_RESET),
        .q       (match[gi*8 +: 8])
      );
    end
  endgenerate

  assign ctrl_wr = reg_wr && (reg_addr == ADDR_CONTROL);

  // Full 32-bit equality, only while enabled and counting
  assign fire = tick && st_reg.aen && st_reg.run && (st_reg.count == match);

  always_comb begin
    ctrl_view                  = 8'h00;
    ctrl_view[CTRL_OSC_EN_BIT] = st_reg.osc_en;
    ctrl_view[CTRL_MCD_EN_BIT] = st_reg.mcd_en;
    ctrl_view[CTRL_FAIL_BIT]   = st_reg.fail;
    ctrl_view[CTRL_RUN_BIT]    = st_reg.run;
    ctrl_view[CTRL_AEN_BIT]    = st_reg.aen;
    ctrl_view[CTRL_ALARM_BIT]  = st_reg.alarm_flag;
    ctrl_view[CTRL_LOAD_BIT]   = st_reg.load_req;
    ctrl_view[CTRL_SNAP_BIT]   = st_reg.snap_req;
  end

  always_comb begin
    st_next = st_reg;

    // Oscillator tick housekeeping
    if (tick) begin
      st_next.alarm_flag = 1'b0;
      st_next.reset_pend = 1'b0;
      if (st_reg.reset_pend) begin
        st_next.count = COUNT_RESET;
      end else if (st_reg.run) begin
        // Plain add wraps through zero
        st_next.count = st_reg.count + 32'h0000_0001;
      end
      if (st_reg.load_req) begin
        // Counter keeps running; no stop needed
        st_next.count    = capture;
        st_next.load_req = 1'b0;
      end
      if (st_reg.snap_req) begin
        st_next.snap_req = 1'b0;
      end
    end

    // Host write of the control byte
    if (ctrl_wr) begin
      st_next.osc_en    = reg_wdata[CTRL_OSC_EN_BIT];
      st_next.mcd_en    = reg_wdata[CTRL_MCD_EN_BIT];
      st_next.run       = reg_wdata[CTRL_RUN_BIT];
      st_next.aen       = reg_wdata[CTRL_AEN_BIT];
      st_next.autoreset = reg_wdata[CTRL_ALARM_BIT];
      if (!reg_wdata[CTRL_FAIL_BIT]) begin
        st_next.fail = 1'b0;
      end
      if (!reg_wdata[CTRL_AEN_BIT]) begin
        st_next.alarm_flag = 1'b0;
      end
      if (reg_wdata[CTRL_LOAD_BIT]) begin
        st_next.load_req = 1'b1;
      end
      if (reg_wdata[CTRL_SNAP_BIT]) begin
        st_next.snap_req = 1'b1;
      end
    end

    // Hardware sets win over clears in the same cycle
    if (timeout) begin
      st_next.fail = 1'b1;
    end
    if (fire) begin
      // Without auto-reset the counter is left alone, so a re-enable waits a full wrap
      st_next.alarm_flag = 1'b1;
      st_next.reset_pend = st_reg.autoreset;
    end

    // Persistent request latched from the event
    if (irq_clear) begin
      st_next.irq  = 1'b0;
      st_next.wake = 1'b0;
    end
    if (fire) begin
      if (alarm_wake_select) begin
        st_next.wake = 1'b1;
      end else begin
        st_next.irq = 1'b1;
      end
    end

    // Registered read data; unmapped reads return zero
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CAPTURE0:          st_next.rdata = capture[7:0];
        ADDR_CAPTURE0 + 4'h1:   st_next.rdata = capture[15:8];
        ADDR_CAPTURE0 + 4'h2:   st_next.rdata = capture[23:16];
        ADDR_CAPTURE0 + 4'h3:   st_next.rdata = capture[31:24];
        ADDR_CONTROL:           st_next.rdata = ctrl_view;
        ADDR_MATCH0:            st_next.rdata = match[7:0];
        ADDR_MATCH0 + 4'h1:     st_next.rdata = match[15:8];
        ADDR_MATCH0 + 4'h2:     st_next.rdata = match[23:16];
        ADDR_MATCH0 + 4'h3:     st_next.rdata = match[31:24];
        default:                st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_reg <= '{osc_en: CTRL_RESET[CTRL_OSC_EN_BIT], mcd_en: CTRL_RESET[CTRL_MCD_EN_BIT],
                  fail: CTRL_RESET[CTRL_FAIL_BIT], run: CTRL_RESET[CTRL_RUN_BIT],
                  aen: CTRL_RESET[CTRL_AEN_BIT], autoreset: CTRL_RESET[CTRL_ALARM_BIT],
                  load_req: CTRL_RESET[CTRL_LOAD_BIT], snap_req: CTRL_RESET[CTRL_SNAP_BIT],
                  alarm_flag: 1'b0, reset_pend: 1'b0, count: COUNT_RESET,
                  rdata: BYTE_RESET, irq: 1'b0, wake: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata   = st_reg.rdata;
  assign osc_enable  = st_reg.osc_en;
  assign alarm_irq   = st_reg.irq;
  assign wake_req    = st_reg.wake;
  assign alarm_event = st_reg.alarm_flag;
endmodule : rta_timer_alarm

// >>> dv/rta_chk_sva.sv
// Port assertions for the timer and alarm block
`timescale 1ns/10ps
module rta_chk
  import rta_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       osc_in,
  input wire logic       osc_enable,
  input wire logic       alarm_wake_select,
  input wire logic       irq_clear,
  input wire logic       alarm_irq,
  input wire logic       wake_req,
  input wire logic       alarm_event
);
  logic osc_reg;
  logic tick;
  logic wr_ctl;
  always_ff @(posedge mclk) osc_reg <= osc_in;
  assign tick   = osc_in & ~osc_reg & osc_enable;
  assign wr_ctl = reg_wr & (reg_addr == ADDR_CONTROL);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_ev_len; alarm_event && tick |=> !alarm_event; endproperty
  a_ev_len: assert property (p_ev_len) else $error("flag too long");
  property p_irq; $rose(alarm_event) && !$past(alarm_wake_select) |-> alarm_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_wake; $rose(alarm_event) && $past(alarm_wake_select) |-> wake_req; endproperty
  a_wake: assert property (p_wake) else $error("wake missing");
  property p_sticky; alarm_irq && !irq_clear |=> alarm_irq; endproperty
  a_sticky: assert property (p_sticky) else $error("irq dropped");
  property p_clr; irq_clear && !tick |=> !alarm_irq && !wake_req; endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_osc; wr_ctl |=> osc_enable == $past(reg_wdata[7]); endproperty
  a_osc: assert property (p_osc) else $error("osc enable wrong");
  property p_aen_off; wr_ctl && !reg_wdata[3] && !tick |=> !alarm_event; endproperty
  a_aen_off: assert property (p_aen_off) else $error("flag not cleared");
  property p_rd_ctl;
    reg_rd && reg_addr == ADDR_CONTROL |=> reg_rdata[7] == $past(osc_enable) && reg_rdata[2] == $past(alarm_event);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");
endmodule : rta_chk
bind rta_timer_alarm rta_chk rta_chk_i (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .osc_in(osc_in), .osc_enable(osc_enable),
  .alarm_wake_select(alarm_wake_select), .irq_clear(irq_clear), .alarm_irq(alarm_irq), .wake_req(wake_req),
  .alarm_event(alarm_event));

// >>> dv/testbench.sv
// Self-checking bench for the timer and alarm block
`timescale 1ns/10ps
module testbench
  import rta_pkg::*;
;
  logic        mclk, rstn, reg_wr, reg_rd, osc_in, sel, irq_clear;
  logic        osc_enable, alarm_irq, wake_req, alarm_event;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic [31:0] v;
  int          miscompares, num_checks;
  rta_timer_alarm #(.MISS_LIMIT(16'h0010)) rta_timer_alarm_i (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .osc_in(osc_in),
    .osc_enable(osc_enable), .alarm_wake_select(sel), .irq_clear(irq_clear), .alarm_irq(alarm_irq),
    .wake_req(wake_req), .alarm_event(alarm_event));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= x;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wr32(input logic [3:0] a, input logic [31:0] x);
    for (int i = 0; i < 4; i++) wr(a + 4'(i), x[8*i+:8]);
  endtask : wr32
  task automatic rd32;
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_CAPTURE0 + 4'(i));
      v[8*i+:8] = d;
    end
  endtask : rd32
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk) osc_in <= 1'b1;
      repeat (4) @(posedge mclk);
      osc_in <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask : pulse
  task automatic poll(input logic [7:0] m);
    for (int i = 0; i < 20; i++) begin
      rd(ADDR_CONTROL);
      if ((d & m) === 8'h00) break;
    end
    chk(d & m, 8'h00);
  endtask : poll
  task automatic t_reset;
    rd(ADDR_CONTROL);
    chk(d, CTRL_RESET);
    rd(4'h6);
    chk(d, 8'h00);
    rd32();
    chk(v, 32'h0);
    chk({alarm_irq, wake_req, alarm_event, osc_enable}, 4'h0);
  endtask : t_reset
  task automatic t_transfer;
    wr32(ADDR_CAPTURE0, 32'h0123_4567);
    wr(ADDR_CONTROL, 8'h82);
    pulse(1);
    poll(8'h02);
    wr32(ADDR_CAPTURE0, 32'h0);
    wr(ADDR_CONTROL, 8'h81);
    pulse(2);
    poll(8'h01);
    rd32();
    chk(v, 32'h0123_4567);
    wr32(ADDR_CAPTURE0, 32'hffff_fffe);
    wr(ADDR_CONTROL, 8'h92);
    pulse(1);
    poll(8'h02);
    pulse(3);
    wr(ADDR_CONTROL, 8'h91);
    pulse(1);
    poll(8'h01);
    rd32();
    chk(v, 32'h1);
  endtask : t_transfer
  task automatic t_alarm;
    wr(ADDR_CONTROL, 8'h90);
    wr32(ADDR_MATCH0, 32'h4);
    wr(ADDR_CONTROL, 8'h9c);
    pulse(2);
    chk(alarm_event, 1'b0);
    pulse(1);
    chk({alarm_event, alarm_irq, wake_req}, 3'b110);
    rd(ADDR_CONTROL);
    chk(d[2], 1'b1);
    pulse(1);
    chk({alarm_event, alarm_irq}, 2'b01);
    wr(ADDR_CONTROL, 8'h9d);
    pulse(1);
    poll(8'h01);
    rd32();
    chk(v, 32'h0);
    @(posedge mclk) irq_clear <= 1'b1;
    @(posedge mclk) irq_clear <= 1'b0;
    #1 chk(alarm_irq, 1'b0);
    @(posedge mclk) sel <= 1'b1;
    pulse(4);
    chk({alarm_event, alarm_irq, wake_req}, 3'b101);
    wr(ADDR_CONTROL, 8'h94);
    #1 chk({alarm_event, wake_req}, 2'b01);
    // Pending clear first, then a plain alarm with auto-reset off
    wr(ADDR_CONTROL, 8'h98);
    pulse(6);
    chk({alarm_event, alarm_irq, wake_req}, 3'b101);
    // Re-enable with the same match: no early alarm
    wr(ADDR_CONTROL, 8'h90);
    wr(ADDR_CONTROL, 8'h98);
    @(posedge mclk) irq_clear <= 1'b1;
    @(posedge mclk) irq_clear <= 1'b0;
    pulse(2);
    chk({alarm_event, alarm_irq, wake_req}, 3'b000);
    wr(ADDR_CONTROL, 8'h99);
    pulse(1);
    poll(8'h01);
    rd32();
    chk(v, 32'h7);
  endtask : t_alarm
  task automatic t_miss;
    wr(ADDR_CONTROL, 8'hc0);
    repeat (8) @(posedge mclk);
    rd(ADDR_CONTROL);
    chk(d[5], 1'b0);
    repeat (40) @(posedge mclk);
    rd(ADDR_CONTROL);
    chk({d[5], osc_enable}, 2'b11);
    wr(ADDR_CONTROL, 8'h40);
    rd(ADDR_CONTROL);
    chk({d[5], osc_enable}, 2'b00);
  endtask : t_miss
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #200us;
    miscompares++;
    test_done();
  end
  initial begin
    {rstn, reg_wr, reg_rd, osc_in, sel, irq_clear} = 6'h0;
    reg_addr    = 4'h0;
    reg_wdata   = 8'h00;
    miscompares = 0;
    num_checks  = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_transfer();
    t_alarm();
    t_miss();
    test_done();
  end
endmodule : testbench
